// file: core/vip_ctrl.sv
`timescale 1ns/1ps
module vip_ctrl (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic interval_tick_src,
  input wire logic serial_done_src,
  input wire logic counter_match_src,
  input wire logic pulse_gen_match_src,
  input wire logic clock_timer_test_src,
  input wire vip_pkg::vip_pins_t pins,
  input wire logic edge_sel_a,
  input wire logic edge_sel_b,
  input wire logic [vip_pkg::NUM_SRC-1:0] source_enable_flag,
  input wire logic global_irq_enable,
  input wire logic [vip_pkg::NUM_SRC-1:0] flag_set,
  input wire logic [vip_pkg::NUM_SRC-1:0] flag_clr,
  output logic [vip_pkg::NUM_SRC-1:0] request_flags,
  output logic standby_wake,
  output logic irq_req,
  output logic [2:0] irq_line,
  input wire logic irq_ack,
  output logic [vip_pkg::PMEM_AW-1:0] pmem_addr,
  output logic pmem_rd,
  input wire logic [7:0] pmem_data,
  output vip_pkg::vip_vec_t vec,
  output logic vec_valid
);
  import vip_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  vip_ctrl_st_t st;                // Registered state
  vip_ctrl_st_t next_st;           // Next state
  logic [NUM_SRC-1:0] ev;          // Hardware events this cycle
  logic [NUM_SRC-1:0] svc_clr;     // Flag cleared by service
  logic [NUM_LINES:1] lreq;        // Gated request per line
  logic fetch_busy;                // Slot read in progress
  logic accept;                    // Core takes the pending request
  logic [NUM_SRC-1:0] armed;       // Flag and enable both set

  // ----------------------------------------------------------------
  // Source events
  // ----------------------------------------------------------------
  // Edge detection against the previous pin sample
  always_comb begin
    ev = '0;
    ev[SRC_TICK] = interval_tick_src;
    ev[SRC_BOTH] = pins.both ^ st.prev.both;
    // Selectable edge; select 0 means rising
    ev[SRC_A] = (edge_sel_a == EDGE_RISE) ? (pins.a & ~st.prev.a)
                                          : (~pins.a & st.prev.a);
    ev[SRC_B] = (edge_sel_b == EDGE_RISE) ? (pins.b & ~st.prev.b)
                                          : (~pins.b & st.prev.b);
    ev[SRC_SERIAL] = serial_done_src;
    ev[SRC_CNT] = counter_match_src;
    ev[SRC_PG] = pulse_gen_match_src;
    // Dedicated pin rising or any key input falling
    ev[SRC_KEY] = (pins.key & ~st.prev.key) | (|(st.prev.kr & ~pins.kr));
    ev[SRC_CLK] = clock_timer_test_src;
  end

  // ----------------------------------------------------------------
  // Request lines and arbitration
  // ----------------------------------------------------------------
  assign armed = st.flags & source_enable_flag;

  // Test sources (key, clock timer) feed no line
  always_comb begin
    lreq = '0;
    // Line 1 merges the two shared sources
    lreq[1] = (armed[SRC_TICK] | armed[SRC_BOTH]) & global_irq_enable;
    // Lines 2..6 map one to one onto sources 2..6
    for (int n = 2; n <= NUM_LINES; n++) begin
      lreq[n] = armed[n] & global_irq_enable;
    end
  end

  // Only one request is taken at a time; the core waits for the slot read
  assign accept = irq_ack & st.pend & ~fetch_busy;

  // Flag cleared when its line is served
  always_comb begin
    svc_clr = '0;
    if (accept) begin
      if (st.line == LINE_TOP) begin
        // Shared line: the tick is served first, the pin source next time
        if (armed[SRC_TICK]) begin
          svc_clr[SRC_TICK] = 1'b1;
        end else begin
          svc_clr[SRC_BOTH] = 1'b1;
        end
      end else begin
        svc_clr[st.line] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Set beats clear so that an event in the clearing cycle survives
  always_comb begin
    next_st = st;
    next_st.prev = pins;
    next_st.flags = (st.flags & ~(flag_clr | svc_clr)) | ev | flag_set;
    next_st.wake = |armed;
    next_st.pend = |lreq;
    next_st.line = 3'h0;
    // Scan from the lowest priority up so the smallest number wins
    for (int n = NUM_LINES; n >= 1; n--) begin
      if (lreq[n]) begin
        next_st.line = 3'(n);
      end
    end
    // Losers keep their flags and win a later scan
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= CTRL_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Slot read and outputs
  // ----------------------------------------------------------------
  vip_vector_fetch u_fetch (
    .sys_clk(sys_clk),
    .rst(rst),
    .start(accept),
    .start_line(st.line),
    .busy(fetch_busy),
    .pmem_addr(pmem_addr),
    .pmem_rd(pmem_rd),
    .pmem_data(pmem_data),
    .vec(vec),
    .vec_valid(vec_valid)
  );

  // Request is hidden while a slot read runs, so acks cannot overlap
  assign irq_req = st.pend & ~fetch_busy;
  assign irq_line = st.line;
  assign request_flags = st.flags;
  assign standby_wake = st.wake;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_line1_route: assert property ((armed[SRC_TICK] || armed[SRC_BOTH]) &&
      global_irq_enable |=> st.pend && st.line == 3'h1)
    else $error("shared source did not win line 1");
  a_both_edge: assert property (pins.both != st.prev.both |=> st.flags[SRC_BOTH])
    else $error("both-edge transition did not set flag");
  a_src_a_line: assert property (lreq[2] && !lreq[1] |=> st.line == 3'h2)
    else $error("source A not on line 2");
  a_src_b_line: assert property (lreq[3] && lreq[2:1] == 2'h0 |=> st.line == 3'h3)
    else $error("source B not on line 3");
  a_serial_line: assert property (lreq[4] && lreq[3:1] == 3'h0 |=> st.line == 3'h4)
    else $error("serial done not on line 4");
  a_counter_line: assert property (lreq[5] && lreq[4:1] == 4'h0 |=> st.line == 3'h5)
    else $error("counter match not on line 5");
  a_pgen_line: assert property (lreq[6] && lreq[5:1] == 5'h00 |=> st.line == 3'h6)
    else $error("pulse generator not on line 6");
  a_test_novec: assert property (armed[SRC_KEY] && armed[SRC_CLK] &&
      armed[NUM_LINES:1] == 6'h00 && !armed[SRC_TICK] |=> !st.pend)
    else $error("test source caused a vectored request");
  a_gie_gate: assert property (!global_irq_enable |=> !st.pend)
    else $error("request pending with global enable off");
  a_wake_cond: assert property (armed != '0 |=> standby_wake)
    else $error("wake missing with armed source");
  a_key_edge: assert property ((st.prev.kr & ~pins.kr) != 8'h00 |=>
      st.flags[SRC_KEY])
    else $error("key input fall did not set flag");
  a_auto_clear: assert property (accept && st.line == 3'h2 && !ev[SRC_A] &&
      !flag_set[SRC_A] |=> !st.flags[SRC_A])
    else $error("served flag not cleared");
  // A line 3 service taken in the same cycle legally clears its flag
  a_loser_held: assert property (lreq[1] && lreq[3] && !flag_clr[SRC_B] &&
      !(accept && st.line == 3'h3) |=> st.flags[SRC_B] ##0 st.line == 3'h1)
    else $error("losing request dropped");
  // Shared line: serving the tick leaves the pin source pending
  a_shared_keep: assert property (accept && st.line == 3'h1 && armed[SRC_TICK] &&
      armed[SRC_BOTH] && !flag_clr[SRC_BOTH] && !ev[SRC_TICK] && !flag_set[SRC_TICK] |=>
      st.flags[SRC_BOTH] && !st.flags[SRC_TICK])
    else $error("shared line flags not served one at a time");
  // An acknowledge with nothing shown starts no slot read
  a_ack_ignored: assert property (irq_ack && !irq_req && !fetch_busy |=> !pmem_rd)
    else $error("slot read started without a request");

  // Main scenarios: served vector, shared line, contention, gated source
  c_accept: cover property (accept ##4 vec_valid);
  c_shared: cover property (lreq[1] && armed[SRC_TICK] && armed[SRC_BOTH]);
  c_contend: cover property (lreq[2] && lreq[6] ##1 accept);
  c_loser: cover property (lreq[1] && lreq[3]);
  c_gated: cover property (st.flags[SRC_SERIAL] && !source_enable_flag[SRC_SERIAL]);

endmodule : vip_ctrl

// file: core/vip_pkg.sv
package vip_pkg;

  // ----------------------------------------------------------------
  // Source indices into the request and enable flag vectors
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 9;
  localparam int SRC_TICK = 0;     // interval_tick_src, shares line 1
  localparam int SRC_BOTH = 1;     // both_edge_ext_src, shares line 1
  localparam int SRC_A = 2;        // ext_edge_src_a, line 2
  localparam int SRC_B = 3;        // ext_edge_src_b, line 3
  localparam int SRC_SERIAL = 4;   // serial_done_src, line 4
  localparam int SRC_CNT = 5;      // counter_match_src, line 5
  localparam int SRC_PG = 6;       // pulse_gen_match_src, line 6
  localparam int SRC_KEY = 7;      // key_edge_test_src, test only
  localparam int SRC_CLK = 8;      // clock_timer_test_src, test only

  // ----------------------------------------------------------------
  // Vector request lines and vector slot layout
  // ----------------------------------------------------------------
  localparam int NUM_LINES = 6;
  localparam logic [2:0] LINE_TOP = 3'h1;   // Priority 1, shared slot
  localparam int PMEM_AW = 14;              // Program address width
  localparam int HI_MBE_BIT = 7;            // First byte: memory bank enable
  localparam int HI_RBE_BIT = 6;            // First byte: register bank enable
  localparam int HI_ADDR_W = 6;             // First byte: upper address bits
  localparam logic [PMEM_AW-1:0] LO_BYTE_STEP = 14'h0001;  // Second slot byte
  localparam logic EDGE_RISE = 1'b0;        // Edge select code for rising

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic mem_bank_enable;                   // mem_bank_enable for the service routine
    logic reg_bank_enable;                   // reg_bank_enable for the service routine
    logic [PMEM_AW-1:0] start;   // Service start address
  } vip_vec_t;

  typedef struct packed {
    logic both;        // both_edge_ext_src pin
    logic a;           // ext_edge_src_a pin
    logic b;           // ext_edge_src_b pin
    logic key;         // key_edge_test_src pin
    logic [7:0] kr;    // key_return_input pins
  } vip_pins_t;

  // ----------------------------------------------------------------
  // State of the two modules
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    F_IDLE = 2'b00,
    F_RD_HI = 2'b01,
    F_RD_LO = 2'b10,
    F_DONE = 2'b11
  } vip_fetch_state_t;

  typedef struct packed {
    vip_pins_t prev;             // Pin levels one cycle back
    logic [NUM_SRC-1:0] flags;   // Request flags
    logic pend;                  // A vectored request is pending
    logic [2:0] line;            // Winning request line
    logic wake;                  // Standby release condition
  } vip_ctrl_st_t;

  typedef struct packed {
    vip_fetch_state_t state;
    logic [PMEM_AW-1:0] addr;    // Program memory address
    logic rd;                    // Program memory read strobe
    logic [7:0] hi;              // First slot byte
    vip_vec_t vec;               // Loaded vector
    logic vld;                   // Vector valid pulse
  } vip_fetch_st_t;

  localparam vip_ctrl_st_t CTRL_RST = '0;    // All flags clear after reset
  localparam vip_fetch_st_t FETCH_RST = '0;

endpackage : vip_pkg

// file: core/vip_vector_fetch.sv
`timescale 1ns/1ps
module vip_vector_fetch (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [2:0] start_line,
  output logic busy,
  output logic [vip_pkg::PMEM_AW-1:0] pmem_addr,
  output logic pmem_rd,
  input wire logic [7:0] pmem_data,
  output vip_pkg::vip_vec_t vec,
  output logic vec_valid
);
  import vip_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  vip_fetch_st_t st;        // Registered state
  vip_fetch_st_t next_st;   // Next state

  // Two-byte slot read; memory answers one cycle after the strobe
  always_comb begin
    next_st = st;
    next_st.vld = 1'b0;
    next_st.rd = 1'b0;
    unique case (st.state)
      F_IDLE: begin
        if (start) begin
          // Slot of line n sits at 2n
          next_st.addr = PMEM_AW'({start_line, 1'b0});
          next_st.rd = 1'b1;
          next_st.state = F_RD_HI;
        end
      end
      F_RD_HI: begin
        // Second byte follows the first
        next_st.addr = st.addr + LO_BYTE_STEP;
        next_st.rd = 1'b1;
        next_st.state = F_RD_LO;
      end
      F_RD_LO: begin
        next_st.hi = pmem_data;
        next_st.state = F_DONE;
      end
      F_DONE: begin
        // Bank bits and start address handed to the core
        next_st.vec.mem_bank_enable = st.hi[HI_MBE_BIT];
        next_st.vec.reg_bank_enable = st.hi[HI_RBE_BIT];
        next_st.vec.start = {st.hi[HI_ADDR_W-1:0], pmem_data};
        next_st.vld = 1'b1;
        next_st.state = F_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= FETCH_RST;
    end else begin
      st <= next_st;
    end
  end

  assign busy = (st.state != F_IDLE);
  assign pmem_addr = st.addr;
  assign pmem_rd = st.rd;
  assign vec = st.vec;
  assign vec_valid = st.vld;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_slot_addr: assert property (start && !busy |=> pmem_rd &&
      pmem_addr == PMEM_AW'({$past(start_line), 1'b0}))
    else $error("vector slot address is not 2n");
  a_lo_byte: assert property (st.state == F_RD_HI |=>
      pmem_rd && pmem_addr == $past(pmem_addr) + LO_BYTE_STEP)
    else $error("second slot byte not read next");
  a_vec_load: assert property (start && !busy |-> ##4 vec_valid)
    else $error("vector not loaded four cycles after start");
  a_vec_bank: assert property (st.state == F_RD_LO ##1 st.state == F_DONE |=>
      vec.mem_bank_enable == $past(pmem_data[HI_MBE_BIT], 2) && vec.reg_bank_enable == $past(pmem_data[HI_RBE_BIT], 2))
    else $error("bank enables not taken from first slot byte");

endmodule : vip_vector_fetch

// file: verif/vip_pmem_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Program memory holding the vector slots
// ----------------------------------------------------------------
module vip_pmem_model
  import vip_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [vip_pkg::PMEM_AW-1:0] pmem_addr,
  input wire logic pmem_rd,
  output logic [7:0] pmem_data
);
  // Slot contents per line; each line gets a distinct address, bank bits follow bit 0 of the line number
  function automatic vip_vec_t slot(input logic [2:0] n);
    slot = {n[0], ~n[0], 3'h5, n, 8'h3c + {5'h0, n}};
  endfunction : slot

  vip_vec_t s; // Slot addressed by the current strobe

  initial begin
    pmem_data = 8'ha5;
  end

  // Byte lands the cycle after the strobe; idle cycles invert the bus
  // so a late sample never sees a stale byte that happens to match
  always @(posedge sys_clk) begin
    s = slot(pmem_addr[3:1]);
    if (pmem_rd) begin
      pmem_data <= pmem_addr[0] ? s.start[7:0] : {s.mem_bank_enable, s.reg_bank_enable, s.start[13:8]};
    end else begin
      pmem_data <= ~pmem_data;
    end
  end
endmodule : vip_pmem_model

// file: verif/vip_ctrl_tb.sv
`timescale 1ns/1ps
module vip_ctrl_tb;
  import vip_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic sys_clk, rst, interval_tick_src, serial_done_src, counter_match_src;
  logic pulse_gen_match_src, clock_timer_test_src, edge_sel_a, edge_sel_b;
  logic global_irq_enable, irq_ack, standby_wake, irq_req, pmem_rd, vec_valid;
  logic [NUM_SRC-1:0] source_enable_flag, flag_set, flag_clr, request_flags;
  logic [2:0] irq_line;
  logic [PMEM_AW-1:0] pmem_addr;
  logic [7:0] pmem_data;
  vip_pins_t pins;
  vip_vec_t vec;
  int miscompares, tests_run;

  // ----------------------------------------------------------------
  // Device and program memory
  // ----------------------------------------------------------------
  vip_ctrl DUT (.sys_clk(sys_clk), .rst(rst), .interval_tick_src(interval_tick_src),
    .serial_done_src(serial_done_src), .counter_match_src(counter_match_src),
    .pulse_gen_match_src(pulse_gen_match_src), .clock_timer_test_src(clock_timer_test_src),
    .pins(pins), .edge_sel_a(edge_sel_a), .edge_sel_b(edge_sel_b),
    .source_enable_flag(source_enable_flag), .global_irq_enable(global_irq_enable),
    .flag_set(flag_set), .flag_clr(flag_clr), .request_flags(request_flags),
    .standby_wake(standby_wake), .irq_req(irq_req), .irq_line(irq_line),
    .irq_ack(irq_ack), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
    .pmem_data(pmem_data), .vec(vec), .vec_valid(vec_valid));

  vip_pmem_model MEM (.sys_clk(sys_clk), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
    .pmem_data(pmem_data));

  // Free running clock
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Expected slot, worked out independently of the device
  function automatic vip_vec_t slot(input logic [2:0] n);
    slot = {n[0], ~n[0], 3'h5, n, 8'h3c + {5'h0, n}};
  endfunction : slot

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One event on the source behind line n
  task automatic fire(input int n);
    case (n)
      1: interval_tick_src = 1'b1;
      2: pins.a = 1'b1;
      3: pins.b = 1'b1;
      4: serial_done_src = 1'b1;
      5: counter_match_src = 1'b1;
      default: pulse_gen_match_src = 1'b1;
    endcase
    @(negedge sys_clk);
    {interval_tick_src, serial_done_src, counter_match_src, pulse_gen_match_src} = 4'h0;
  endtask : fire

  // Core side: wait for a request, accept it, follow the slot read
  task automatic serve(input logic [2:0] n, input int s);
    int i;
    for (i = 0; i < 20 && irq_req !== 1'b1; i++) @(negedge sys_clk);
    chk("irq_req", 16'h1, {15'h0, irq_req});
    chk("irq_line", {13'h0, n}, {13'h0, irq_line});
    irq_ack = 1'b1;
    @(negedge sys_clk);
    irq_ack = 1'b0;
    chk("slot_hi", {12'h0, n, 1'b0}, {2'h0, pmem_addr});
    chk("slot_rd", 16'h1, {15'h0, pmem_rd});
    chk("served_flag", 16'h0, {15'h0, request_flags[s]});
    @(negedge sys_clk);
    chk("slot_lo", {12'h0, n, 1'b1}, {2'h0, pmem_addr});
    for (i = 0; i < 6 && vec_valid !== 1'b1; i++) @(negedge sys_clk);
    chk("vec_valid", 16'h1, {15'h0, vec_valid});
    chk("vec", slot(n), vec);
  endtask : serve

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  // Hang guard, far beyond the under two hundred cycles the tests need
  initial begin
    repeat (3000) @(posedge sys_clk);
    miscompares++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {interval_tick_src, serial_done_src, counter_match_src} = 3'h0;
    {pulse_gen_match_src, clock_timer_test_src, edge_sel_a, edge_sel_b} = 4'h0;
    {irq_ack, flag_set, flag_clr} = '0;
    global_irq_enable = 1'b1;
    source_enable_flag = 9'h1ff;
    // Key input 3 idles high, the others low, so only a falling edge counts later
    pins = '0;
    pins.kr = 8'h08;
    miscompares = 0;
    tests_run = 0;
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("flags_reset", 16'h0, {7'h0, request_flags});
    chk("req_reset", 16'h0, {15'h0, irq_req});
    $display("test reset done");
    // Every line from its real source
    for (int n = 1; n <= 6; n++) begin
      fire(n);
      serve(3'(n), (n == 1) ? SRC_TICK : n);
    end
    $display("test lines done");
    // Both edges of the shared pin each raise a request
    pins.both = 1'b1;
    serve(3'h1, SRC_BOTH);
    pins.both = 1'b0;
    serve(3'h1, SRC_BOTH);
    $display("test both_edge done");
    // Two requests in one cycle: line 6 waits its turn behind line 2
    flag_set = 9'h044;
    @(negedge sys_clk);
    flag_set = '0;
    serve(3'h2, SRC_A);
    chk("loser_pending", 16'h1, {15'h0, request_flags[SRC_PG]});
    serve(3'h6, SRC_PG);
    $display("test priority done");
    // Global enable off blocks the request but not the wake
    global_irq_enable = 1'b0;
    fire(5);
    repeat (3) @(negedge sys_clk);
    chk("req_masked", 16'h0, {15'h0, irq_req});
    chk("wake", 16'h1, {15'h0, standby_wake});
    global_irq_enable = 1'b1;
    serve(3'h5, SRC_CNT);
    $display("test global done");
    // Falling edge selected on both edge pins; pins are high from earlier
    edge_sel_a = 1'b1;
    edge_sel_b = 1'b1;
    pins.a = 1'b0;
    serve(3'h2, SRC_A);
    pins.b = 1'b0;
    serve(3'h3, SRC_B);
    $display("test edge_select done");
    // Shared line with both sources set, plus a waiting line 3
    flag_set = 9'h00b;
    @(negedge sys_clk);
    flag_set = '0;
    serve(3'h1, SRC_TICK);
    chk("shared_pending", 16'h1, {15'h0, request_flags[SRC_BOTH]});
    serve(3'h1, SRC_BOTH);
    serve(3'h3, SRC_B);
    $display("test shared done");
    // Disabled source: flag sets (set beats clear) but no request, no wake
    source_enable_flag[SRC_SERIAL] = 1'b0;
    flag_clr = 9'h010;
    fire(4);
    flag_clr = '0;
    repeat (2) @(negedge sys_clk);
    chk("gated_flag", 16'h1, {15'h0, request_flags[SRC_SERIAL]});
    chk("gated_req", 16'h0, {15'h0, irq_req});
    chk("gated_wake", 16'h0, {15'h0, standby_wake});
    source_enable_flag[SRC_SERIAL] = 1'b1;
    serve(3'h4, SRC_SERIAL);
    $display("test enable done");
    // Test-only sources set flags and wake, never vector
    clock_timer_test_src = 1'b1;
    pins.key = 1'b1;
    @(negedge sys_clk);
    clock_timer_test_src = 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("test_flags", 16'h3, {14'h0, request_flags[8:7]});
    chk("test_no_req", 16'h0, {15'h0, irq_req});
    chk("test_wake", 16'h1, {15'h0, standby_wake});
    flag_clr = 9'h180;
    @(negedge sys_clk);
    flag_clr = '0;
    repeat (2) @(negedge sys_clk);
    chk("key_clr", 16'h0, {15'h0, request_flags[SRC_KEY]});
    pins.kr = 8'h00;
    repeat (3) @(negedge sys_clk);
    chk("key_return", 16'h1, {15'h0, request_flags[SRC_KEY]});
    chk("key_no_req", 16'h0, {15'h0, irq_req});
    $display("test test_sources done");
    give_verdict();
  end
endmodule : vip_ctrl_tb
